/* src/mct_pkg.sv */
// Package with timing constants and types for the machine cycle sequencer
package mct_pkg;
  localparam int unsigned OSC_DIVIDE     = 3;
  localparam int unsigned STATES_PER_CYC = 5;
  localparam logic [1:0]  DIV_LAST       = 2'h2;
  localparam logic [1:0]  DIV_RESET      = 2'h0;
  localparam logic        CLKOUT_RESET   = 1'b0;
  localparam int unsigned PC_WIDTH       = 12;
  localparam int unsigned NIBBLE_WIDTH   = 4;
  localparam logic [11:0] PC_RESET       = 12'h000;
  localparam logic [7:0]  TIMER_RESET    = 8'h00;

  typedef enum logic [4:0] {
    MCT_S1 = 5'h01,
    MCT_S2 = 5'h02,
    MCT_S3 = 5'h04,
    MCT_S4 = 5'h08,
    MCT_S5 = 5'h10
  } mct_state_t;
endpackage

/* src/mct_phase_if.sv */
// Interface carrying the divider tick between the prescaler and the sequencer
`timescale 1ns/10ps
`default_nettype none
interface mct_phase_if;
  logic tick;
  logic phase_mid;
  modport src (output tick, output phase_mid);
  modport dst (input tick, input phase_mid);
endinterface
`default_nettype wire

/* src/mct_prescaler.sv */
// Divide-by-three prescaler that marks each basic clock cycle
`timescale 1ns/10ps
`default_nettype none
module mct_prescaler
  import mct_pkg::*;
(
  // Clock and control
  input  wire logic  clock,
  input  wire logic  rst_n,
  input  wire logic  clk_en,
  // Phase output
  mct_phase_if.src   ph
);
  logic [1:0] div_reg;
  logic [1:0] div_next;

  always_comb begin
    div_next = (div_reg == DIV_LAST) ? DIV_RESET : div_reg + 2'h1;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      div_reg <= DIV_RESET;
    end else if (clk_en) begin
      div_reg <= div_next;
    end
  end

  // Tick marks the oscillator cycle that closes a basic clock cycle
  assign ph.tick      = clk_en && (div_reg == DIV_LAST);
  assign ph.phase_mid = (div_reg == DIV_RESET);
endmodule
`default_nettype wire

/* src/mct_sequencer.sv */
// Timing and control sequencer: five machine states per instruction cycle
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Basic clock cycle is the oscillator frequency divided by three.
// - Each basic clock cycle is one machine state.
// - Instruction cycle is five consecutive states, repeating without end.
// - Test pin outputs basic clock only after clock-output enable instruction.
// - Reset disables clock output; test pin becomes an input.
// - Address latch strobe produced once per machine cycle, continually.
// - Expander write drives low nibble of second port in state five.
// - External fetch presents valid instruction address in the designated state.
// - Dedicated expander strobe generated beside read, write, program store, latch strobes.
module mct_sequencer
  import mct_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    clk_en,
  // Instruction decode hints
  input  wire logic                    clock_out_enable_instr,
  input  wire logic                    expander_move_instr,
  input  wire logic                    two_cycle_instr,
  input  wire logic                    external_fetch,
  input  wire logic                    bus_read_req,
  input  wire logic                    bus_write_req,
  input  wire logic                    timer_run,
  input  wire logic [NIBBLE_WIDTH-1:0] expander_data,
  input  wire logic [PC_WIDTH-1:0]     jump_target,
  input  wire logic                    jump_taken,
  // Test pin
  input  wire logic                    test_clock_pin_in,
  output logic                         test_clock_pin_out,
  output logic                         test_clock_pin_oe,
  output logic                         test_input_level,
  // Strobes
  output logic                         address_latch_strobe,
  output logic                         program_store_strobe_n,
  output logic                         read_strobe_n,
  output logic                         write_strobe_n,
  output logic                         expander_strobe,
  // Second port low nibble and address
  output logic [NIBBLE_WIDTH-1:0]      second_io_port_out,
  output logic                         second_io_port_oe,
  output logic [PC_WIDTH-1:0]          fetch_address,
  // Sequencer status
  output logic [4:0]                   machine_state,
  output logic                         second_cycle,
  output logic                         opcode_fetch,
  output logic                         timer_increment,
  output logic                         port_action,
  output logic [7:0]                   timer_count
);
  mct_phase_if ph ();

  mct_prescaler u_prescaler (
    .clock (clock),
    .rst_n (rst_n),
    .clk_en(clk_en),
    .ph    (ph)
  );

  // Sequencer state
  mct_state_t              st_reg, st_next;
  logic                    cyc2_reg, cyc2_next;
  logic                    clkout_reg, clkout_next;
  logic                    tclk_reg, tclk_next;
  logic [2:0]              tsync_reg, tsync_next;
  logic                    tlevel_reg, tlevel_next;
  logic                    ale_reg, ale_next;
  logic                    pstb_n_reg, pstb_n_next;
  logic                    rd_n_reg, rd_n_next;
  logic                    wr_n_reg, wr_n_next;
  logic                    xstb_reg, xstb_next;
  logic [NIBBLE_WIDTH-1:0] nib_reg, nib_next;
  logic                    p2oe_reg, p2oe_next;
  logic [PC_WIDTH-1:0]     pc_reg, pc_next;
  logic [PC_WIDTH-1:0]     faddr_reg, faddr_next;
  logic                    fetch_reg, fetch_next;
  logic                    tinc_reg, tinc_next;
  logic                    port_reg, port_next;
  logic [7:0]              timer_reg, timer_next;

  always_comb begin
    st_next     = st_reg;
    cyc2_next   = cyc2_reg;
    clkout_next = clkout_reg;
    tclk_next   = tclk_reg;
    tsync_next  = {tsync_reg[1:0], test_clock_pin_in};
    tlevel_next = (tsync_reg[2] == tsync_reg[1]) ? tsync_reg[2] : tlevel_reg;
    ale_next    = ale_reg;
    pstb_n_next = pstb_n_reg;
    rd_n_next   = rd_n_reg;
    wr_n_next   = wr_n_reg;
    xstb_next   = xstb_reg;
    nib_next    = nib_reg;
    p2oe_next   = p2oe_reg;
    pc_next     = pc_reg;
    faddr_next  = faddr_reg;
    fetch_next  = 1'b0;
    tinc_next   = 1'b0;
    port_next   = 1'b0;
    timer_next  = timer_reg;
    // Basic clock toggles mid-cycle so the test pin shows a divide-by-three wave
    if (ph.phase_mid) begin
      tclk_next = 1'b1;
    end
    if (ph.tick) begin
      tclk_next = 1'b0;
      unique case (st_reg)
        MCT_S1: begin
          st_next   = MCT_S2;
          ale_next  = 1'b0;
          pstb_n_next = 1'b1;
          if (!cyc2_reg || two_cycle_instr) begin
            fetch_next = 1'b1;
          end
        end
        MCT_S2: begin
          st_next = MCT_S3;
          if (!cyc2_reg) begin
            pc_next = pc_reg + 12'h001;
          end
          rd_n_next = !(cyc2_reg && bus_read_req);
        end
        MCT_S3: begin
          st_next   = MCT_S4;
          rd_n_next = 1'b1;
          if (cyc2_reg && two_cycle_instr) begin
            pc_next = jump_taken ? jump_target : pc_reg + 12'h001;
          end
          if (!cyc2_reg && expander_move_instr) begin
            xstb_next = 1'b1;
          end
          if (!cyc2_reg && bus_write_req) begin
            wr_n_next = 1'b0;
          end
        end
        MCT_S4: begin
          st_next   = MCT_S5;
          wr_n_next = 1'b1;
          if (!cyc2_reg) begin
            tinc_next = 1'b1;
            if (timer_run) begin
              timer_next = timer_reg + 8'h01;
            end
            // Nibble stands for all of S5 so it is settled before the strobe falls
            if (expander_move_instr) begin
              nib_next  = expander_data;
              p2oe_next = 1'b1;
            end
          end
        end
        MCT_S5: begin
          st_next   = MCT_S1;
          cyc2_next = !cyc2_reg && two_cycle_instr;
          // Address is set up here so it is stable before the latch strobe falls
          ale_next   = 1'b1;
          faddr_next = pc_reg;
          pstb_n_next = !external_fetch;
          // Cleared every S5 so a move dropped mid-cycle cannot leave the strobe stuck
          xstb_next  = 1'b0;
          if (!cyc2_reg) begin
            port_next = 1'b1;
          end
          if (!cyc2_reg && clock_out_enable_instr) begin
            clkout_next = 1'b1;
          end
        end
        default: begin
          st_next = MCT_S1;
        end
      endcase
    end
    if (ph.tick && st_reg == MCT_S1 && !expander_move_instr) begin
      p2oe_next = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_reg     <= MCT_S1;
      cyc2_reg   <= 1'b0;
      clkout_reg <= CLKOUT_RESET;
      tclk_reg   <= 1'b0;
      tsync_reg  <= 3'h0;
      tlevel_reg <= 1'b0;
      ale_reg    <= 1'b0;
      pstb_n_reg <= 1'b1;
      rd_n_reg   <= 1'b1;
      wr_n_reg   <= 1'b1;
      xstb_reg   <= 1'b0;
      nib_reg    <= 4'h0;
      p2oe_reg   <= 1'b0;
      pc_reg     <= PC_RESET;
      faddr_reg  <= PC_RESET;
      fetch_reg  <= 1'b0;
      tinc_reg   <= 1'b0;
      port_reg   <= 1'b0;
      timer_reg  <= TIMER_RESET;
    end else if (clk_en) begin
      st_reg     <= st_next;
      cyc2_reg   <= cyc2_next;
      clkout_reg <= clkout_next;
      tclk_reg   <= tclk_next;
      tsync_reg  <= tsync_next;
      tlevel_reg <= tlevel_next;
      ale_reg    <= ale_next;
      pstb_n_reg <= pstb_n_next;
      rd_n_reg   <= rd_n_next;
      wr_n_reg   <= wr_n_next;
      xstb_reg   <= xstb_next;
      nib_reg    <= nib_next;
      p2oe_reg   <= p2oe_next;
      pc_reg     <= pc_next;
      faddr_reg  <= faddr_next;
      fetch_reg  <= fetch_next;
      tinc_reg   <= tinc_next;
      port_reg   <= port_next;
      timer_reg  <= timer_next;
    end
  end

  assign test_clock_pin_out     = tclk_reg;
  assign test_clock_pin_oe      = clkout_reg;
  assign test_input_level       = tlevel_reg;
  assign address_latch_strobe   = ale_reg;
  assign program_store_strobe_n = pstb_n_reg;
  assign read_strobe_n          = rd_n_reg;
  assign write_strobe_n         = wr_n_reg;
  assign expander_strobe        = xstb_reg;
  assign second_io_port_out     = nib_reg;
  assign second_io_port_oe      = p2oe_reg;
  assign fetch_address          = faddr_reg;
  assign machine_state          = st_reg;
  assign second_cycle           = cyc2_reg;
  assign opcode_fetch           = fetch_reg;
  assign timer_increment        = tinc_reg;
  assign port_action            = port_reg;
  assign timer_count            = timer_reg;
endmodule
`default_nettype wire

/* bench/mct_ext_mem.sv */
// Partner model: external memory address latch and I/O expander nibble latch
`timescale 1ns/10ps
`default_nettype none
module mct_ext_mem
  import mct_pkg::*;
(
  // Bus side
  input  wire logic                    clock,
  input  wire logic                    address_latch_strobe,
  input  wire logic                    expander_strobe,
  input  wire logic [PC_WIDTH-1:0]     fetch_address,
  input  wire logic [NIBBLE_WIDTH-1:0] second_io_port_out,
  // Captured values
  output logic      [PC_WIDTH-1:0]     latched_addr,
  output logic      [NIBBLE_WIDTH-1:0] expander_nibble
);
  logic ale_q = 1'b0;
  logic exp_q = 1'b0;
  always @(posedge clock) begin
    ale_q <= address_latch_strobe;
    exp_q <= expander_strobe;
    if (ale_q && !address_latch_strobe) latched_addr <= fetch_address;
    // Data is taken once the strobe has dropped, when the nibble is on the port
    if (exp_q && !expander_strobe) expander_nibble <= second_io_port_out;
  end
endmodule
`default_nettype wire

/* bench/mct_seq_asserts.sv */
// Concurrent checks on the machine cycle sequencer ports
`timescale 1ns/10ps
`default_nettype none
module mct_seq_asserts
  import mct_pkg::*;
(
  // Clock and inputs
  input wire logic                    clock,
  input wire logic                    rst_n,
  input wire logic                    clk_en,
  input wire logic                    clock_out_enable_instr,
  input wire logic [NIBBLE_WIDTH-1:0] expander_data,
  // Watched outputs
  input wire logic                    test_clock_pin_out,
  input wire logic                    test_clock_pin_oe,
  input wire logic                    address_latch_strobe,
  input wire logic                    program_store_strobe_n,
  input wire logic                    expander_strobe,
  input wire logic [NIBBLE_WIDTH-1:0] second_io_port_out,
  input wire logic                    second_io_port_oe,
  input wire logic [PC_WIDTH-1:0]     fetch_address,
  input wire logic [4:0]              machine_state,
  input wire logic                    timer_increment,
  input wire logic                    port_action,
  input wire logic [7:0]              timer_count,
  input wire logic                    read_strobe_n,
  input wire logic                    write_strobe_n,
  input wire logic                    second_cycle,
  input wire logic                    opcode_fetch
);
  default clocking cb @(posedge clock); endclocking
  // A frozen sequencer is not a fault, so checks other than chk_reset_clkout pause while clk_en is low
  default disable iff (!rst_n || !clk_en);
  sequence ale_pulse;
    address_latch_strobe[*3] ##1 !address_latch_strobe;
  endsequence
  chk_ale_period: assert property (
    $rose(address_latch_strobe) |-> ale_pulse ##12 $rose(address_latch_strobe))
    else $error("latch strobe period wrong");
  chk_state_order: assert property (
    $changed(machine_state) |->
      machine_state == (($past(machine_state) << 1) | ($past(machine_state) >> 4)))
    else $error("machine state order wrong");
  chk_state_hold: assert property (
    $changed(machine_state) |=> $stable(machine_state)[*2] ##1 $changed(machine_state))
    else $error("machine state length wrong");
  chk_reset_clkout: assert property (disable iff (1'b0)
    !rst_n |=> !test_clock_pin_oe)
    else $error("clock output still enabled after reset");
  chk_clkout_cause: assert property (
    $rose(test_clock_pin_oe) |-> $past(clock_out_enable_instr))
    else $error("clock output enabled without instruction");
  chk_clkout_rate: assert property (
    test_clock_pin_oe && $rose(test_clock_pin_out) |-> ##3 $rose(test_clock_pin_out))
    else $error("test pin clock rate wrong");
  chk_expander_data: assert property (
    $fell(expander_strobe) |-> second_io_port_oe && second_io_port_out == expander_data)
    else $error("expander nibble missing at strobe fall");
  chk_fetch_stable: assert property (
    $fell(program_store_strobe_n) |=> $stable(fetch_address)[*2])
    else $error("fetch address moved during fetch");
  chk_timer_step: assert property (
    $changed(timer_count) |-> timer_count == $past(timer_count) + 8'h01)
    else $error("timer step wrong");
  chk_port_after_timer: assert property (
    timer_increment |-> ##3 port_action)
    else $error("port action not one state after timer");
  sequence rd_window;
    (!read_strobe_n)[*3] ##1 read_strobe_n;
  endsequence
  sequence wr_window;
    (!write_strobe_n)[*3] ##1 write_strobe_n;
  endsequence
  chk_read_window: assert property (
    $fell(read_strobe_n) |-> second_cycle && machine_state == MCT_S3 ##0 rd_window)
    else $error("read strobe outside second cycle S3");
  chk_write_window: assert property (
    $fell(write_strobe_n) |-> !second_cycle && machine_state == MCT_S4 ##0 wr_window)
    else $error("write strobe outside first cycle S4");
  chk_nibble_in_s5: assert property (
    expander_strobe && machine_state == MCT_S5 |->
      second_io_port_oe && second_io_port_out == expander_data)
    else $error("expander nibble not driven in S5");
  chk_fetch_at_s1: assert property (
    $fell(address_latch_strobe) && !second_cycle |-> opcode_fetch)
    else $error("opcode fetch missing at end of S1");
endmodule
bind mct_sequencer mct_seq_asserts u_chk (.clock, .rst_n, .clk_en, .clock_out_enable_instr,
  .expander_data, .test_clock_pin_out, .test_clock_pin_oe, .address_latch_strobe,
  .program_store_strobe_n, .expander_strobe, .second_io_port_out, .second_io_port_oe,
  .fetch_address, .machine_state, .timer_increment, .port_action, .timer_count,
  .read_strobe_n, .write_strobe_n, .second_cycle, .opcode_fetch);
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking testbench for the machine cycle sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import mct_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, clk_en = 1'b1, coe = 1'b0, emov = 1'b0, two = 1'b0;
  logic xf = 1'b0, rdq = 1'b0, wrq = 1'b0, trun = 1'b0, jt = 1'b0, tpin = 1'b0;
  logic [3:0] edata = 4'h0;
  logic [11:0] tgt = 12'h000;
  logic ale, oe, tco, pstb_n, xstb, poe, tlev;
  logic [3:0] pout, nib;
  logic [11:0] faddr, laddr;
  logic [4:0] mstate;
  logic [7:0] tcount;
  int fails = 0, tests_run = 0;
  always #5 clock = ~clock;
  mct_sequencer uut (.clock, .rst_n, .clk_en, .clock_out_enable_instr(coe),
    .expander_move_instr(emov), .two_cycle_instr(two), .external_fetch(xf),
    .bus_read_req(rdq), .bus_write_req(wrq), .timer_run(trun), .expander_data(edata),
    .jump_target(tgt), .jump_taken(jt), .test_clock_pin_in(tpin),
    .test_clock_pin_out(tco), .test_clock_pin_oe(oe), .test_input_level(tlev),
    .address_latch_strobe(ale), .program_store_strobe_n(pstb_n), .read_strobe_n(),
    .write_strobe_n(), .expander_strobe(xstb), .second_io_port_out(pout),
    .second_io_port_oe(poe), .fetch_address(faddr), .machine_state(mstate),
    .second_cycle(), .opcode_fetch(), .timer_increment(), .port_action(),
    .timer_count(tcount));
  mct_ext_mem partner (.clock, .address_latch_strobe(ale), .expander_strobe(xstb),
    .fetch_address(faddr), .second_io_port_out(pout), .latched_addr(laddr),
    .expander_nibble(nib));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (fails == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Counts clocks until n rising edges of the latch strobe have been seen
  task automatic wait_ale(input int n, output int clks);
    logic prev;
    clks = 0;
    prev = ale;
    while (n > 0 && clks < 200) begin
      @(posedge clock); #1;
      clks++;
      if (ale && !prev) n--;
      prev = ale;
    end
    if (n > 0) check(16'(n), 16'h0);
  endtask
  task automatic grab(output logic [11:0] a);
    int c;
    wait_ale(1, c);
    @(posedge clock); #1;
    check({15'h0, pstb_n}, 16'h0);
    repeat (4) @(posedge clock);
    #1 a = laddr;
  endtask
  task automatic t_cadence;
    int c;
    wait_ale(1, c);
    check({11'h0, mstate}, {11'h0, MCT_S1});
    wait_ale(1, c);
    check(16'(c), 16'h000f);
  endtask
  task automatic t_clkout;
    int c;
    time t0;
    check({15'h0, oe}, 16'h0);
    @(negedge clock) coe = 1'b1;
    wait_ale(2, c);
    @(negedge clock) coe = 1'b0;
    check({15'h0, oe}, 16'h1);
    @(posedge tco) t0 = $time;
    @(posedge tco) check(16'(($time - t0) / 10), 16'h3);
    @(negedge clock) rst_n = 1'b0;
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    check({15'h0, oe}, 16'h0);
    tpin = 1'b1;
    repeat (4) @(posedge clock);
    #1 check({15'h0, tlev}, 16'h1);
  endtask
  task automatic t_expander;
    for (int i = 0; i < 2; i++) begin
      @(negedge clock) edata = (i == 0) ? 4'h9 : 4'h6;
      emov = 1'b1;
      @(negedge xstb) #1 check({12'h0, pout}, {12'h0, edata});
      @(posedge clock) #1 check({12'h0, nib}, {12'h0, edata});
    end
    @(negedge clock) emov = 1'b0;
  endtask
  task automatic t_timer;
    logic [7:0] v;
    int c;
    @(negedge clock) trun = 1'b1;
    wait_ale(1, c);
    v = tcount;
    wait_ale(4, c);
    check({8'h0, tcount}, {8'h0, 8'(v + 8'h04)});
  endtask
  task automatic t_freeze;
    logic [4:0] s;
    logic [7:0] v;
    @(negedge clock) clk_en = 1'b0;
    s = mstate;
    v = tcount;
    repeat (7) @(negedge clock);
    check({11'h0, mstate}, {11'h0, s});
    check({8'h0, tcount}, {8'h0, v});
    clk_en = 1'b1;
  endtask
  task automatic t_fetch;
    logic [11:0] a0, a1, a2;
    @(negedge clock) xf = 1'b1;
    grab(a0);
    grab(a0);
    grab(a1);
    check({4'h0, a1}, {4'h0, 12'(a0 + 12'h001)});
    @(negedge clock) {two, jt, rdq, wrq} = 4'hf;
    tgt = 12'h5a5;
    repeat (3) grab(a0);
    grab(a0);
    grab(a1);
    grab(a2);
    if (a0 === tgt) check({4'h0, a1}, 16'h05a6);
    else begin
      check({4'h0, a0}, 16'h05a6);
      check({4'h0, a1}, 16'h05a5);
    end
    check({4'h0, a2}, {4'h0, a0});
  endtask
  initial begin
    #100000;
    fails++;
    end_sim;
  end
  initial begin
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    t_cadence;
    t_clkout;
    t_expander;
    t_timer;
    t_freeze;
    t_fetch;
    end_sim;
  end
endmodule
`default_nettype wire
